// ### ddw_defs.svh
// constants of the dual converter serial write port
// assumes inclusion by bare name from the design and testbench files
`ifndef DDW_DEFS_SVH
`define DDW_DEFS_SVH
`define DDW_WORD_BITS 16
`define DDW_CNT_FULL 5'h10
`define DDW_CNT_ZERO 5'h00
`define DDW_CODE_MAX 12'hffc
`define DDW_CODE_RST 12'h000
`define DDW_OFS_CTRL 8'h00
`define DDW_OFS_DACA 8'h04
`define DDW_OFS_DACB 8'h08
`define DDW_OFS_HOLD 8'h0c
`define DDW_OFS_MODE 8'h10
`define DDW_OFS_WCNT 8'h14
`define DDW_OFS_LAST 8'h14
`define DDW_RESP_OKAY 2'h0
`define DDW_RESP_SLVERR 2'h2
`endif

// ### ddw_pkg.sv
// types of the dual converter serial write port
// assumes ddw_defs.svh is on the include path
`default_nettype none
package ddw_pkg;
  // received serial word, msb first on the wire
  typedef struct packed {
    logic        regSelectHigh;
    logic        speedSelectBit;
    logic        powerDownBit;
    logic        regSelectLow;
    logic [11:0] data;
  } ddw_word_t;
  // register-select decode
  typedef enum logic [1:0] {
    DDW_SEL_B_HOLD = 2'h0,
    DDW_SEL_HOLD   = 2'h1,
    DDW_SEL_A_XFER = 2'h2,
    DDW_SEL_RSVD   = 2'h3
  } ddw_sel_t;
  // settling and power mode
  typedef struct packed {
    logic fast;
    logic pwrDown;
  } ddw_mode_t;
endpackage : ddw_pkg
`default_nettype wire

// ### ddw_serial_dac.sv
// serial write port of a dual converter with an axi4-lite status slave
// assumes sclk, csN and din come from an external serial master,
// and mclk/resetn from the system; sclk may stop between frames
//
// Function
// - output code equals latched code, range 0x000 to 0xffc of 0x1000
// - reset clears both converter latches and the holding buffer
// - select fall starts frame; bits taken msb first on falling sclk
// - after sixteen bits or select rise, word goes to chosen latch
// - addressed register updates at sixteenth rising sclk edge, no strobe
// - word: d15 rs high, d14 speed, d13 power, d12 rs low, d11..d0 data
// - speed bit one gives fast mode, zero gives slow mode
// - power bit one enters power-down, zero returns to normal
// - power-up clears speed and power bits
// - select 00 writes data into converter b and holding buffer
// - select 01 writes holding buffer only; 11 is reserved
// - select 10 loads converter a and copies buffer into converter b
// - the twelve-bit data field is the new converter value
// - addressed output changes at rising sclk edge after d0
// - simultaneous update changes both outputs together
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "ddw_defs.svh"

module ddw_serial_dac #(
  parameter int ADDR_W = 8
) (
  // system
  input  wire logic              mclk,
  input  wire logic              resetn,
  // serial link
  input  wire logic              sclk,
  input  wire logic              csN,
  input  wire logic              din,
  // converter side
  output logic [11:0]            dacCodeA,
  output logic [11:0]            dacCodeB,
  output logic                   fastMode,
  output logic                   powerDown,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // ****************************************
  // link domain (sclk)
  // ****************************************
  logic [15:0] shiftReg;
  logic [4:0]  bitCnt;
  logic        armReg;
  logic        doneReg;
  logic        tglReg;
  logic [15:0] wordReg;

  // armed while select is high; first falling edge restarts the count
  always_ff @(negedge sclk or posedge csN or negedge resetn) begin
    if (!resetn) begin
      armReg <= 1'b1;
    end else if (csN) begin
      armReg <= 1'b1;
    end else begin
      armReg <= 1'b0;
    end
  end

  // count is not cleared by select, so a short frame stays readable
  always_ff @(negedge sclk or negedge resetn) begin
    if (!resetn) begin
      shiftReg <= 16'h0000;
      bitCnt   <= `DDW_CNT_ZERO;
    end else if (!csN) begin
      if (armReg) begin
        shiftReg <= {15'h0000, din};
        bitCnt   <= 5'h01;
      end else if (bitCnt != `DDW_CNT_FULL) begin
        shiftReg <= {shiftReg[14:0], din};
        bitCnt   <= bitCnt + 5'h01;
      end
    end
  end

  // word handed over once, at the rising edge after d0
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      doneReg <= 1'b0;
      wordReg <= 16'h0000;
      tglReg  <= 1'b0;
    end else begin
      doneReg <= (bitCnt == `DDW_CNT_FULL);
      if (bitCnt == `DDW_CNT_FULL && !doneReg && !csN) begin
        wordReg <= shiftReg;
        tglReg  <= ~tglReg;
      end
    end
  end

  // ****************************************
  // crossing into mclk
  // ****************************************
  logic tglMeta;
  logic tglSync;
  logic tglPrev;
  logic csMeta;
  logic csSync;
  logic csPrev;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tglMeta <= 1'b0;
      tglSync <= 1'b0;
      tglPrev <= 1'b0;
    end else begin
      tglMeta <= tglReg;
      tglSync <= tglMeta;
      tglPrev <= tglSync;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      csMeta <= 1'b1;
      csSync <= 1'b1;
      csPrev <= 1'b1;
    end else begin
      csMeta <= csN;
      csSync <= csMeta;
      csPrev <= csSync;
    end
  end

  // shiftReg, bitCnt and doneReg are still while select is high and
  // sclk idle, so they are read here as settled words
  logic                wordPulse;
  logic                csRise;
  logic                commitValid;
  ddw_pkg::ddw_word_t  commitWord;
  ddw_pkg::ddw_sel_t   commitSel;

  assign wordPulse   = tglSync ^ tglPrev;
  assign csRise      = csSync & ~csPrev;
  assign commitValid = wordPulse
                     | (csRise & (bitCnt != `DDW_CNT_ZERO) & ~doneReg);
  assign commitWord  = wordPulse ? ddw_pkg::ddw_word_t'(wordReg)
                                 : ddw_pkg::ddw_word_t'(shiftReg);
  assign commitSel   = ddw_pkg::ddw_sel_t'({commitWord.regSelectHigh,
                                            commitWord.regSelectLow});

  // ****************************************
  // latches
  // ****************************************
  logic [11:0]        dacAReg;
  logic [11:0]        dacBReg;
  logic [11:0]        holdReg;
  ddw_pkg::ddw_mode_t modeReg;
  logic [15:0]        wordCntReg;
  logic               clrReg;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dacAReg <= `DDW_CODE_RST;
      dacBReg <= `DDW_CODE_RST;
      holdReg <= `DDW_CODE_RST;
    end else if (commitValid) begin
      unique case (commitSel)
        ddw_pkg::DDW_SEL_B_HOLD: begin
          dacBReg <= commitWord.data;
          holdReg <= commitWord.data;
        end
        ddw_pkg::DDW_SEL_HOLD: begin
          holdReg <= commitWord.data;
        end
        ddw_pkg::DDW_SEL_A_XFER: begin
          dacAReg <= commitWord.data;
          dacBReg <= holdReg;
        end
        ddw_pkg::DDW_SEL_RSVD: begin
          // reserved select leaves every latch alone
          holdReg <= holdReg;
        end
      endcase
    end else if (clrReg) begin
      dacAReg <= `DDW_CODE_RST;
      dacBReg <= `DDW_CODE_RST;
      holdReg <= `DDW_CODE_RST;
    end
  end

  // mode bits follow every accepted word, reserved select included
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      modeReg <= '0;
    end else if (commitValid) begin
      modeReg.fast    <= commitWord.speedSelectBit;
      modeReg.pwrDown <= commitWord.powerDownBit;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wordCntReg <= 16'h0000;
    end else if (commitValid) begin
      wordCntReg <= wordCntReg + 16'h0001;
    end
  end

  // codes above 0xffc cannot be produced by the resistor string
  assign dacCodeA  = (dacAReg > `DDW_CODE_MAX) ? `DDW_CODE_MAX : dacAReg;
  assign dacCodeB  = (dacBReg > `DDW_CODE_MAX) ? `DDW_CODE_MAX : dacBReg;
  assign fastMode  = modeReg.fast;
  assign powerDown = modeReg.pwrDown;

  // ****************************************
  // axi4-lite write
  // ****************************************
  logic              awHeld;
  logic              wHeld;
  logic [ADDR_W-1:0] awAddrReg;
  logic [31:0]       wDataReg;
  logic              wStrb0Reg;
  logic              bValidReg;
  logic [1:0]        bRespReg;
  logic              doWrite;

  assign s_axi_awready = ~awHeld & ~bValidReg;
  assign s_axi_wready  = ~wHeld & ~bValidReg;
  assign doWrite       = awHeld & wHeld & ~bValidReg;
  assign s_axi_bvalid  = bValidReg;
  assign s_axi_bresp   = bRespReg;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      awHeld    <= 1'b0;
      awAddrReg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld    <= 1'b1;
      awAddrReg <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld    <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wHeld     <= 1'b0;
      wDataReg  <= 32'h0000_0000;
      wStrb0Reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld     <= 1'b1;
      wDataReg  <= s_axi_wdata;
      wStrb0Reg <= s_axi_wstrb[0];
    end else if (doWrite) begin
      wHeld     <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bValidReg <= 1'b0;
      bRespReg  <= `DDW_RESP_OKAY;
    end else if (doWrite) begin
      bValidReg <= 1'b1;
      bRespReg  <= (awAddrReg[1:0] == 2'h0 && awAddrReg <= ADDR_W'(`DDW_OFS_LAST))
                 ? `DDW_RESP_OKAY : `DDW_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValidReg <= 1'b0;
    end
  end

  // clear pulse loses to a serial word landing in the same cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      clrReg <= 1'b0;
    end else begin
      clrReg <= doWrite && wStrb0Reg && wDataReg[0]
              && awAddrReg == ADDR_W'(`DDW_OFS_CTRL);
    end
  end

  // ****************************************
  // axi4-lite read
  // ****************************************
  logic        rValidReg;
  logic [31:0] rDataReg;
  logic [1:0]  rRespReg;
  logic [31:0] rdMux;
  logic        rdHit;

  assign s_axi_arready = ~rValidReg;
  assign s_axi_rvalid  = rValidReg;
  assign s_axi_rdata   = rDataReg;
  assign s_axi_rresp   = rRespReg;

  always_comb begin
    rdMux = 32'h0000_0000;
    rdHit = 1'b1;
    unique case (s_axi_araddr)
      ADDR_W'(`DDW_OFS_CTRL): rdMux = 32'h0000_0000;
      ADDR_W'(`DDW_OFS_DACA): rdMux = {20'h00000, dacAReg};
      ADDR_W'(`DDW_OFS_DACB): rdMux = {20'h00000, dacBReg};
      ADDR_W'(`DDW_OFS_HOLD): rdMux = {20'h00000, holdReg};
      ADDR_W'(`DDW_OFS_MODE): rdMux = {30'h00000000, modeReg.pwrDown, modeReg.fast};
      ADDR_W'(`DDW_OFS_WCNT): rdMux = {16'h0000, wordCntReg};
      default:                rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rValidReg <= 1'b0;
      rDataReg  <= 32'h0000_0000;
      rRespReg  <= `DDW_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValidReg <= 1'b1;
      rDataReg  <= rdMux;
      rRespReg  <= rdHit ? `DDW_RESP_OKAY : `DDW_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rValidReg <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_CODE_RANGE: assert property (@(posedge mclk) disable iff (!resetn)
    dacCodeA <= `DDW_CODE_MAX && dacCodeB <= `DDW_CODE_MAX)
    else $error("converter code above range");

  AST_CLEAR_ZERO: assert property (@(posedge mclk) disable iff (!resetn)
    clrReg && !commitValid |=> dacAReg == 12'h000 && dacBReg == 12'h000 && holdReg == 12'h000)
    else $error("latches not cleared");

  AST_BIT_COUNT: assert property (@(negedge sclk) disable iff (!resetn)
    !csN && !armReg && bitCnt != 5'h10 |=> bitCnt == $past(bitCnt) + 5'h01)
    else $error("bit count did not advance");

  AST_SHORT_FRAME: assert property (@(posedge mclk) disable iff (!resetn)
    csRise && bitCnt != 5'h00 && !doneReg |-> commitValid ##1 wordCntReg == $past(wordCntReg) + 16'h0001)
    else $error("short frame not committed");

  AST_WORD_TAKEN: assert property (@(posedge mclk) disable iff (!resetn)
    $changed(tglSync) |=> wordCntReg == $past(wordCntReg) + 16'h0001)
    else $error("full word not committed");

  AST_SEL_B: assert property (@(posedge mclk) disable iff (!resetn)
    commitValid && commitSel == ddw_pkg::DDW_SEL_B_HOLD
    |=> dacBReg == $past(commitWord.data) && holdReg == $past(commitWord.data) && $stable(dacAReg))
    else $error("select 00 mishandled");

  AST_SEL_HOLD: assert property (@(posedge mclk) disable iff (!resetn)
    commitValid && commitSel == ddw_pkg::DDW_SEL_HOLD
    |=> holdReg == $past(commitWord.data) && $stable(dacAReg) && $stable(dacBReg))
    else $error("select 01 touched a converter");

  AST_SEL_A: assert property (@(posedge mclk) disable iff (!resetn)
    commitValid && commitSel == ddw_pkg::DDW_SEL_A_XFER
    |=> dacAReg == $past(commitWord.data) && dacBReg == $past(holdReg))
    else $error("select 10 mishandled");

  AST_MODE: assert property (@(posedge mclk) disable iff (!resetn)
    commitValid |=> fastMode == $past(commitWord.speedSelectBit))
    else $error("speed mode wrong");

  AST_POWER: assert property (@(posedge mclk) disable iff (!resetn)
    commitValid |=> powerDown == $past(commitWord.powerDownBit))
    else $error("power-down wrong");

endmodule : ddw_serial_dac
`default_nettype wire

// ### ddw_host_model.sv
// serial host model: drives select, serial clock and data of one word
// assumes the caller leaves select high long enough between words
`timescale 1ns/10ps
`default_nettype none
module ddw_host_model (
  // serial link
  output logic sclk,
  output logic csN,
  output logic din
);
  initial begin
    sclk = 1'b1;
    csN  = 1'b1;
    din  = 1'b0;
  end
  // sclk stands high between frames, 32 ns period inside a frame
  task automatic sendWord(input logic [15:0] w, input bit split);
    w[1:0] = 2'h0;
    #7 csN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      #6 din = w[i];
      #10 sclk = 1'b0;
      #16 sclk = 1'b1;
      if (split && i == 8) #40;
    end
    #16 csN = 1'b1;
    // released data line must not keep showing the last bit
    din = ~din;
  endtask : sendWord
  // select rises after the sixteenth falling edge but before the rising one,
  // so the word is moved on the select edge instead of the clock edge
  task automatic sendEarly(input logic [15:0] w);
    w[1:0] = 2'h0;
    #7 csN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      #6 din = w[i];
      #10 sclk = 1'b0;
      if (i == 0) begin
        #12 csN = 1'b1;
        #40;
      end
      #16 sclk = 1'b1;
    end
    din = ~din;
  endtask : sendEarly
endmodule : ddw_host_model
`default_nettype wire

// ### testbench.sv
// self-checking bench of the dual converter serial write port
// assumes ddw_pkg, ddw_defs.svh and the host model are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "ddw_defs.svh"
module testbench;
  logic        mclk, resetn;
  wire         sclk, csN, din;
  logic [11:0] dacCodeA, dacCodeB;
  logic        fastMode, powerDown;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  int          num_errors, num_checks;

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  ddw_serial_dac i_dut (.mclk, .resetn, .sclk, .csN, .din, .dacCodeA, .dacCodeB, .fastMode, .powerDown,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  ddw_host_model i_host (.sclk, .csN, .din);

  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // every axi handshake wait goes through here so a hang ends the run
  task automatic tick(inout int n);
    @(posedge mclk);
    n++;
    if (n > 200) begin
      num_errors++;
      stop_test();
    end
  endtask : tick

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    bit aD, wD;
    n = 0;
    aD = 0;
    wD = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aD && wD)) begin
      tick(n);
      if (!aD && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        aD = 1;
      end
      if (!wD && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        wD = 1;
      end
    end
    do tick(n); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    // bready stays high between writes, so back-to-back calls never toggle it
  endtask : axiWrite

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do tick(n); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do tick(n); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : axiRead

  // one word over the link, then room for its commit across domains
  task automatic frame(input ddw_pkg::ddw_sel_t s, input logic f, p, input logic [11:0] d, input bit split);
    i_host.sendWord({s[1], f, p, s[0], d}, split);
    repeat (20) @(posedge mclk);
  endtask : frame

  task automatic checkAll(input logic [11:0] a, b, h, input logic [1:0] m);
    chk("dacCodeA", {20'h0, a}, {20'h0, dacCodeA});
    chk("dacCodeB", {20'h0, b}, {20'h0, dacCodeB});
    chk("mode pins", {30'h0, m}, {30'h0, powerDown, fastMode});
    axiRead(`DDW_OFS_DACA, rd, rsp);
    chk("DACA", {20'h0, a}, rd);
    axiRead(`DDW_OFS_DACB, rd, rsp);
    chk("DACB", {20'h0, b}, rd);
    axiRead(`DDW_OFS_HOLD, rd, rsp);
    chk("HOLD", {20'h0, h}, rd);
    axiRead(`DDW_OFS_MODE, rd, rsp);
    chk("MODE", {30'h0, m}, rd);
  endtask : checkAll

  initial begin
    num_errors = 0;
    num_checks = 0;
    resetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata  = 32'h0;
    s_axi_wstrb  = 4'hf;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    checkAll(12'h000, 12'h000, 12'h000, 2'h0);
    frame(ddw_pkg::DDW_SEL_B_HOLD, 1'b1, 1'b0, 12'habc, 0);
    checkAll(12'h000, 12'habc, 12'habc, 2'h1);
    frame(ddw_pkg::DDW_SEL_HOLD, 1'b0, 1'b0, 12'h124, 0);
    checkAll(12'h000, 12'habc, 12'h124, 2'h0);
    // byte-wide host: two halves under one select
    frame(ddw_pkg::DDW_SEL_A_XFER, 1'b0, 1'b0, 12'hffc, 1);
    checkAll(12'hffc, 12'h124, 12'h124, 2'h0);
    // power bit decides power-down whatever else the word holds; select 11 is never sent
    frame(ddw_pkg::DDW_SEL_HOLD, 1'b1, 1'b1, 12'h550, 0);
    checkAll(12'hffc, 12'h124, 12'h550, 2'h3);
    frame(ddw_pkg::DDW_SEL_HOLD, 1'b0, 1'b0, 12'h000, 0);
    checkAll(12'hffc, 12'h124, 12'h000, 2'h0);
    // select rises between the sixteenth falling and rising edges
    i_host.sendEarly({4'h0, 12'h3a8});
    repeat (20) @(posedge mclk);
    checkAll(12'hffc, 12'h3a8, 12'h3a8, 2'h0);
    axiRead(`DDW_OFS_WCNT, rd, rsp);
    chk("WCNT", 32'h6, rd);
    axiWrite(`DDW_OFS_DACA, 32'h123, rsp);
    chk("ro bresp", {30'h0, `DDW_RESP_OKAY}, {30'h0, rsp});
    axiWrite(8'h02, 32'h1, rsp);
    chk("misaligned bresp", {30'h0, `DDW_RESP_SLVERR}, {30'h0, rsp});
    axiRead(8'h18, rd, rsp);
    chk("unmapped rresp", {30'h0, `DDW_RESP_SLVERR}, {30'h0, rsp});
    chk("unmapped rdata", 32'h0, rd);
    checkAll(12'hffc, 12'h3a8, 12'h3a8, 2'h0);
    axiWrite(`DDW_OFS_CTRL, 32'h1, rsp);
    repeat (4) @(posedge mclk);
    checkAll(12'h000, 12'h000, 12'h000, 2'h0);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
